// [rtl/dual_wiper_serial_slave.sv]
`timescale 1ns/1ps
module dual_wiper_serial_slave #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h6 // Arbitrary value
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [3:0] ADDR_SELECT_PINS_I,
  input wire logic WRITE_GUARD_N_I,
  output logic READY_O,
  output logic [7:0] WIPER0_POS_O,
  output logic [7:0] WIPER1_POS_O,
  output logic [255:0] TAP0_SEL_O,
  output logic [255:0] TAP1_SEL_O
);

  localparam logic [255:0] TAP_ONE = 256'h1;

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic guard_s1_reg, guard_s2_reg;
  logic [3:0] pins_s1_reg, pins_s2_reg;

  wiper_pkg::link_state_e state_reg, nxt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_hold_reg;
  logic drive_low_reg;
  logic [3:0] op_reg;
  logic [1:0] slot_reg;
  logic ch_reg;
  logic ready_reg;
  logic [1:0] rec_cnt_reg;
  logic [7:0] wiper_reg [wiper_pkg::CHANNELS];
  logic [255:0] tap_sel [wiper_pkg::CHANNELS];

  // Only the second stages and their delayed copies feed logic
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
      {guard_s1_reg, guard_s2_reg} <= 2'h0;
      pins_s1_reg <= 4'h0;
      pins_s2_reg <= 4'h0;
    end else begin
      scl_s1_reg <= SCL_I;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= SDA_I;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      guard_s1_reg <= WRITE_GUARD_N_I;
      guard_s2_reg <= guard_s1_reg;
      pins_s1_reg <= ADDR_SELECT_PINS_I;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  wire byte_full = bit_cnt_reg == wiper_pkg::BITS_PER_BYTE;
  wire byte_done = scl_fall & byte_full & ~ack_hold_reg;

  wire id_match = shift_reg == {DEV_TYPE_ID, pins_s2_reg};
  wire [3:0] op_in = shift_reg[wiper_pkg::OP_MSB:wiper_pkg::OP_LSB];
  wire op_read = op_in == wiper_pkg::OP_RD_WIPER ||
                 op_in == wiper_pkg::OP_RD_SLOT;
  wire op_known = op_read || op_in == wiper_pkg::OP_WR_WIPER ||
                  op_in == wiper_pkg::OP_WR_SLOT;
  wire instr_ok = op_known & ~shift_reg[wiper_pkg::FIXED_ZERO_POS];

  wire in_wdata = byte_done & (state_reg == wiper_pkg::ST_WDATA);
  wire wr_wiper_en = in_wdata & (op_reg == wiper_pkg::OP_WR_WIPER);
  wire mem_we = in_wdata & (op_reg == wiper_pkg::OP_WR_SLOT) &
                guard_s2_reg;
  wire rec_ch = rec_cnt_reg != 2'h0;
  wire [2:0] mem_addr = ready_reg ? {ch_reg, slot_reg} :
                        {rec_ch, wiper_pkg::DEFAULT_SLOT};
  wire [7:0] mem_rdata;
  wire [7:0] tx_byte = (op_reg == wiper_pkg::OP_RD_WIPER) ?
                       wiper_reg[ch_reg] : mem_rdata;
  wire [2:0] tx_idx = 3'h7 - bit_cnt_reg[2:0];

  slot_mem #(
    .DW(wiper_pkg::DATA_W),
    .AW(wiper_pkg::MEM_AW),
    .RESET_VAL(wiper_pkg::SLOT_RESET_VAL)
  ) u_slot_mem (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(shift_reg),
    .rdata_o(mem_rdata)
  );

  // Recall: address default slot, then load each wiper in turn
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rec_cnt_reg <= 2'h0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      rec_cnt_reg <= rec_cnt_reg + 2'h1;
      ready_reg <= rec_cnt_reg == 2'h2;
    end
  end

  for (genvar c = 0; c < wiper_pkg::CHANNELS; c++) begin : g_chan
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        wiper_reg[c] <= 8'h00;
      end else if (!ready_reg && rec_cnt_reg == 2'(c + 1)) begin
        wiper_reg[c] <= mem_rdata;
      end else if (wr_wiper_en && ch_reg == 1'(c)) begin
        wiper_reg[c] <= shift_reg;
      end
    end
    assign tap_sel[c] = TAP_ONE << wiper_reg[c];
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= wiper_pkg::ST_IDLE;
      nxt_reg <= wiper_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_hold_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (start_det && ready_reg) begin
      state_reg <= wiper_pkg::ST_ID;
      bit_cnt_reg <= 4'h0;
      ack_hold_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= wiper_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_hold_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (scl_rise && state_reg != wiper_pkg::ST_IDLE) begin
      if (!byte_full) begin
        shift_reg <= {shift_reg[6:0], sda_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else begin
        bit_cnt_reg <= 4'h0;
        if (state_reg == wiper_pkg::ST_RDATA && sda_s2_reg) begin
          state_reg <= wiper_pkg::ST_SKIP;
        end
      end
    end else if (scl_fall) begin
      if (ack_hold_reg) begin
        ack_hold_reg <= 1'b0;
        state_reg <= nxt_reg;
        drive_low_reg <= (nxt_reg == wiper_pkg::ST_RDATA) &
                         ~tx_byte[7];
      end else if (byte_done) begin
        case (state_reg)
          wiper_pkg::ST_ID: begin
            if (id_match) begin
              ack_hold_reg <= 1'b1;
              drive_low_reg <= 1'b1;
              nxt_reg <= wiper_pkg::ST_INSTR;
            end else begin
              state_reg <= wiper_pkg::ST_SKIP;
            end
          end
          wiper_pkg::ST_INSTR: begin
            if (instr_ok) begin
              ack_hold_reg <= 1'b1;
              drive_low_reg <= 1'b1;
              nxt_reg <= op_read ? wiper_pkg::ST_RDATA :
                         wiper_pkg::ST_WDATA;
            end else begin
              state_reg <= wiper_pkg::ST_SKIP;
            end
          end
          wiper_pkg::ST_WDATA: begin
            ack_hold_reg <= 1'b1;
            drive_low_reg <= 1'b1;
            nxt_reg <= wiper_pkg::ST_SKIP;
          end
          wiper_pkg::ST_RDATA: begin
            drive_low_reg <= 1'b0;
          end
          default: begin
            drive_low_reg <= 1'b0;
          end
        endcase
      end else if (state_reg == wiper_pkg::ST_RDATA) begin
        drive_low_reg <= ~tx_byte[tx_idx];
      end
    end
  end

  // Instruction fields are latched with the instruction byte
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      op_reg <= 4'h0;
      slot_reg <= 2'h0;
      ch_reg <= 1'b0;
    end else if (byte_done && state_reg == wiper_pkg::ST_INSTR) begin
      op_reg <= op_in;
      slot_reg <= {shift_reg[wiper_pkg::SLOT_HI_POS],
                   shift_reg[wiper_pkg::SLOT_LO_POS]};
      ch_reg <= shift_reg[wiper_pkg::CHAN_POS];
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = drive_low_reg;
  assign READY_O = ready_reg;
  assign WIPER0_POS_O = wiper_reg[0];
  assign WIPER1_POS_O = wiper_reg[1];
  assign TAP0_SEL_O = tap_sel[0];
  assign TAP1_SEL_O = tap_sel[1];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_instr_taken;
    byte_done && state_reg == wiper_pkg::ST_INSTR && instr_ok;
  endsequence

  property p_rx_sample;
    scl_rise && state_reg != wiper_pkg::ST_IDLE && !byte_full
      |=> shift_reg[0] == $past(sda_s2_reg);
  endproperty
  a_rx_sample: assert property (p_rx_sample)
    else $error("incoming bit not taken on clock rise");

  property p_drive_on_fall;
    $changed(drive_low_reg) |-> $past(scl_fall || start_det || stop_det);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("data line changed outside a clock fall");

  property p_open_drain;
    SDA_OE_O |-> !SDA_O;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");

  property p_addr_mismatch;
    byte_done && state_reg == wiper_pkg::ST_ID && !id_match
      |=> state_reg == wiper_pkg::ST_SKIP && !drive_low_reg;
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch)
    else $error("foreign address answered");

  property p_chan_indep;
    wr_wiper_en && !ch_reg |=> wiper_reg[1] == $past(wiper_reg[1]);
  endproperty
  a_chan_indep: assert property (p_chan_indep)
    else $error("write to one wiper changed the other");

  property p_one_tap;
    $onehot(TAP0_SEL_O) && TAP0_SEL_O[WIPER0_POS_O] &&
      $onehot(TAP1_SEL_O) && TAP1_SEL_O[WIPER1_POS_O];
  endproperty
  a_one_tap: assert property (p_one_tap)
    else $error("tap select not one-hot on wiper value");

  property p_recall;
    !ready_reg && rec_cnt_reg == 2'h2
      |=> ready_reg && wiper_reg[1] == $past(mem_rdata);
  endproperty
  a_recall: assert property (p_recall)
    else $error("power-up recall did not load wiper");

  property p_no_cmd_early;
    !ready_reg |-> state_reg == wiper_pkg::ST_IDLE;
  endproperty
  a_no_cmd_early: assert property (p_no_cmd_early)
    else $error("command served before recall");

  property p_ack_addr;
    byte_done && state_reg == wiper_pkg::ST_ID && id_match
      |=> drive_low_reg && ack_hold_reg;
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("matching address not acknowledged");

  // The line stays pulled low for the whole ninth clock
  property p_ack_hold;
    ack_hold_reg |-> drive_low_reg;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released before clock fall");

  property p_slot_decode;
    s_instr_taken |=> slot_reg == $past(shift_reg[3:2]) &&
      ch_reg == $past(shift_reg[0]);
  endproperty
  a_slot_decode: assert property (p_slot_decode)
    else $error("slot or channel select misdecoded");

  property p_guard;
    !guard_s2_reg |-> !mem_we;
  endproperty
  a_guard: assert property (p_guard)
    else $error("saved slot written while guarded");

endmodule : dual_wiper_serial_slave

// [rtl/slot_mem.sv]
`timescale 1ns/1ps
module slot_mem #(
  parameter int DW = 8,
  parameter int AW = 3,
  parameter logic [7:0] RESET_VAL = 8'h80
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [2**AW];

  // Stored contents come back as the reset value in simulation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= RESET_VAL[DW-1:0];
      end
    end else if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_reg[addr_i];
    end
  end

  property p_slot_store;
    @(posedge clk_i) disable iff (!arst_n_i)
    we_i |=> mem_reg[$past(addr_i)] == $past(wdata_i);
  endproperty
  a_slot_store: assert property (p_slot_store)
    else $error("saved slot did not take written value");

endmodule : slot_mem

// [rtl/wiper_pkg.sv]
package wiper_pkg;

  localparam int DATA_W = 8;
  localparam int TAPS = 256;
  localparam int CHANNELS = 2;
  localparam int SLOTS = 4;
  localparam int MEM_AW = 3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] DEFAULT_SLOT = 2'h0;
  localparam logic [7:0] SLOT_RESET_VAL = 8'h80;

  // Instruction byte layout: opcode, slot select, fixed zero, channel
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SLOT_HI_POS = 3;
  localparam int SLOT_LO_POS = 2;
  localparam int FIXED_ZERO_POS = 1;
  localparam int CHAN_POS = 0;

  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_SLOT = 4'hb;
  localparam logic [3:0] OP_WR_SLOT = 4'hc;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ID,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } link_state_e;

endpackage : wiper_pkg

// [sim/bus_master_model.sv]
`timescale 1ns/1ps
module bus_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Quarter of the 125 ns bus clock period
  localparam realtime QTR = 31.25;

  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Works from idle and as a repeated start
  task automatic start();
    #QTR sda_oe_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_oe_o = 1'b1;
    #QTR scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #QTR sda_oe_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_oe_o = 1'b0;
    #QTR;
  endtask : stop

  // Data changes only while the clock is low
  task automatic bit_xfer(input logic b, output logic r);
    #QTR sda_oe_o = ~b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
  endtask : bit_xfer

  // Eight bits MSB first, then the ninth bit; 1 releases the line
  task automatic xfer(input logic [7:0] w, input logic ninth,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(w[i], r[i]);
    end
    bit_xfer(ninth, ack);
  endtask : xfer
endmodule : bus_master_model

// [sim/dual_wiper_serial_slave_test.sv]
`timescale 1ns/1ps
module dual_wiper_serial_slave_test;
  localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary value
  localparam logic [3:0] PINS = 4'h9;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] pins = PINS;
  logic guard_n = 1'b1;
  logic scl, m_oe, dev_oe, dev_sda, ready;
  logic [7:0] w0, w1;
  logic [255:0] t0, t1;
  logic [7:0] v;
  logic [7:0] r1, r2;
  logic a1;
  int failures = 0;
  int samples_checked = 0;
  // Pull-up: line high unless someone pulls it low
  wire sda = (dev_oe ? dev_sda : 1'b1) & ~m_oe;

  always #5 clk = ~clk;

  dual_wiper_serial_slave #(.DEV_TYPE_ID(TYPE_ID)) dual_wiper_serial_slave_i (
    .CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(dev_sda), .SDA_OE_O(dev_oe), .ADDR_SELECT_PINS_I(pins),
    .WRITE_GUARD_N_I(guard_n), .READY_O(ready), .WIPER0_POS_O(w0),
    .WIPER1_POS_O(w1), .TAP0_SEL_O(t0), .TAP1_SEL_O(t1));

  bus_master_model bus_master_model_i (
    .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] ins(input logic [3:0] op,
                                     input logic [1:0] s, input logic ch);
    return {op, s, 1'b0, ch};
  endfunction : ins

  // One framed transfer: ID byte, instruction, one data byte
  task automatic op(input logic [7:0] i, input logic [7:0] d,
                    input int is_rd, input logic [2:0] exp_ack,
                    input logic [7:0] exp_r);
    logic [7:0] junk;
    logic [7:0] r;
    logic [2:0] acks;
    @(posedge clk);
    #1;
    bus_master_model_i.start();
    bus_master_model_i.xfer({TYPE_ID, PINS}, 1'b1, junk, acks[2]);
    bus_master_model_i.xfer(i, 1'b1, junk, acks[1]);
    bus_master_model_i.xfer(is_rd ? 8'hff : d, 1'b1, r, acks[0]);
    bus_master_model_i.stop();
    repeat (6) @(posedge clk);
    #1;
    check(acks, exp_ack);
    if (is_rd) check(r, exp_r);
  endtask : op

  task automatic wait_ready();
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
    repeat (5) @(posedge clk);
    #1;
  endtask : wait_ready

  initial begin
    repeat (5) @(posedge clk);
    #1;
    check(ready, 1'b0);
    check(dev_oe, 1'b0);
    arst_n = 1'b1;
    wait_ready();
    check(ready, 1'b1);
    check(w0, 8'h80);
    check(w1, 8'h80);
    check(t0, 256'h1 << 8'h80);
    op(ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h00, 0, 3'h0, 8'h00);
    op(ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b1), 8'hff, 0, 3'h0, 8'h00);
    check(w0, 8'h00);
    check(w1, 8'hff);
    check(t0, 256'h1);
    check(t1, 256'h1 << 8'hff);
    op(ins(wiper_pkg::OP_RD_WIPER, 2'h0, 1'b1), 8'h00, 1, 3'h1, 8'hff);
    // Master acks the first byte, so the same wiper comes out again
    bus_master_model_i.start();
    bus_master_model_i.xfer({TYPE_ID, PINS}, 1'b1, v, a1);
    bus_master_model_i.xfer(ins(wiper_pkg::OP_RD_WIPER, 2'h0, 1'b0), 1'b1,
                            v, a1);
    bus_master_model_i.xfer(8'hff, 1'b0, r1, a1);
    bus_master_model_i.xfer(8'hff, 1'b1, r2, a1);
    bus_master_model_i.stop();
    repeat (6) @(posedge clk);
    #1;
    check({r1, r2}, 16'h0000);
    pins = 4'h3;
    op(ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b0), 8'h55, 0, 3'h7, 8'h00);
    check(w0, 8'h00);
    pins = PINS;
    op(ins(wiper_pkg::OP_WR_WIPER, 2'h0, 1'b0) | 8'h02, 8'h55, 0,
       3'h3, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        v = {2'h1, c[0], s[1:0], 3'h3};
        op(ins(wiper_pkg::OP_WR_SLOT, s[1:0], c[0]), v, 0, 3'h0, 8'h00);
      end
    end
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        v = {2'h1, c[0], s[1:0], 3'h3};
        op(ins(wiper_pkg::OP_RD_SLOT, s[1:0], c[0]), 8'h00, 1, 3'h1,
           v);
      end
    end
    guard_n = 1'b0;
    op(ins(wiper_pkg::OP_WR_SLOT, 2'h2, 1'b1), 8'h00, 0, 3'h0, 8'h00);
    guard_n = 1'b1;
    op(ins(wiper_pkg::OP_RD_SLOT, 2'h2, 1'b1), 8'h00, 1, 3'h1, 8'h73);
    arst_n = 1'b0;
    @(posedge clk);
    #1;
    check(ready, 1'b0);
    arst_n = 1'b1;
    wait_ready();
    check(w0, 8'h80);
    check(t1, 256'h1 << 8'h80);
    check(dev_sda, 1'b0);
    stop_test();
  end

  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule : dual_wiper_serial_slave_test
